// file: hw/dtg_dial_gen.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "dtg_consts.svh"

// Summary of operation
// R01 - Key held: tone pair sounds until release
// R02 - Toggle mode: each press flips generator
// R03 - Level as total/twist or row/column
// R04 - Positive twist: column louder than row
// R05 - Per-tone percent error, +/-20%, plus Hz
// R06 - Frequency is nominal times percent, plus Hz
// R07 - String digit on time, then pause
// R08 - Start dials stored digits in order
// R09 - Per-symbol level, frequency, timing offsets; code applies them to string digits only, keypad tones get none
// R10 - Sixteen symbols each own offset entry
// R11 - Offsets all zero after reset
// R12 - Pause offset changes following gap only
// R13 - Delay option: go off hook, wait, dial
// R14 - On-hook dialing needs AC termination, no delay
// R15 - On hook: only AC termination transmits
// R16 - Standard nominal row/column frequencies
// R17 - Sum sinusoids; mute between digits, stopped
module dtg_dial_gen #(
    parameter int MS_CYCLES = `DTG_MS_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Register port
    input wire dtg_pkg::dtg_bus_s bus_i,
    output logic [31:0] rdata_o,
    // Line side
    output logic off_hook_o,
    output logic line_tx_en_o,
    output logic signed [15:0] sample_o,
    output logic busy_o
);
    import dtg_pkg::*;

    localparam logic [11:0] SAMPLE_LAST = 12'(`DTG_SAMPLE_CYCLES - 1);
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    dtg_state_e state, next_state;
    dtg_ofs_s ofs_mem [16];
    logic [11:0] ctrl;
    dtg_pair_s lvl_tt, lvl_rc, ferr_pct, ferr_hz;
    logic [15:0] on_ms, pause_ms, delay_ms;
    logic [31:0] digits;
    logic [4:0] keypad;
    logic [3:0] ofs_sel;
    logic off_hook, tog_on, refused;
    logic [2:0] dig_idx;
    logic [15:0] ms_pre, tmr;
    logic [11:0] smp_pre;
    logic [15:0] ph_r, ph_c;

    // Register decode
    wire wr_ctrl = bus_i.wr && bus_i.addr == `DTG_CTRL;
    wire wr_key = bus_i.wr && bus_i.addr == `DTG_KEYPAD;
    wire start_req = wr_ctrl && bus_i.wdata[`DTG_C_START];
    wire stop_req = wr_ctrl && bus_i.wdata[`DTG_C_STOP];
    wire key_rise = wr_key && bus_i.wdata[`DTG_K_DOWN] && !keypad[`DTG_K_DOWN];
    wire ms_tick = ms_pre == MS_LAST;
    wire smp_tick = smp_pre == SAMPLE_LAST;

    // Level forms: the stored source form wins, the other is derived
    wire lvl_src_rc = ctrl[`DTG_C_LVL_RC];
    wire signed [15:0] tw_half = lvl_tt.col >>> 1;
    wire signed [15:0] row_db = lvl_src_rc ? lvl_rc.row : lvl_tt.row - tw_half; // [R03] [R04]
    wire signed [15:0] col_db = lvl_src_rc ? lvl_rc.col : lvl_tt.row + tw_half; // [R03] [R04]
    wire signed [16:0] sum_db = 17'(row_db) + 17'(col_db);
    wire signed [15:0] tot_db = sum_db[16:1];
    wire signed [15:0] twist_db = col_db - row_db;

    // Active symbol and its offsets
    wire string_mode = state == DTG_TONE || state == DTG_PAUSE || state == DTG_HOOKWAIT;
    wire [3:0] sym = string_mode ? digits[{dig_idx, 2'b00} +: 4] : keypad[3:0]; // [R08]
    wire dtg_ofs_s so = string_mode ? ofs_mem[sym] : '0; // [R09] [R10]
    // A start may arrive in the same write that sets hook, mode or length: judge it by the new values
    wire [11:0] ctrl_now = wr_ctrl ? {bus_i.wdata[11:6], 2'b00, bus_i.wdata[3:0]} : ctrl;
    wire hook_now = wr_ctrl ? bus_i.wdata[`DTG_C_HOOK] : off_hook;
    wire [3:0] n_len = ctrl_now[`DTG_C_LEN];
    wire last_digit = {1'b0, dig_idx} == n_len - 4'h1;

    // Transmission permission on hook
    wire ac_term = ctrl_now[`DTG_C_ACM] == DTG_AC_TERM;
    wire tx_ok = hook_now || (ac_term && !ctrl_now[`DTG_C_DLY_EN]); // [R14] [R15]

    // Symbol code: 0-9, a-d = A-D, e = star, f = hash
    function automatic logic [3:0] sym_grid(input logic [3:0] s);
        case (s)
            4'h1: sym_grid = 4'h0;
            4'h2: sym_grid = 4'h1;
            4'h3: sym_grid = 4'h2;
            4'ha: sym_grid = 4'h3;
            4'h4: sym_grid = 4'h4;
            4'h5: sym_grid = 4'h5;
            4'h6: sym_grid = 4'h6;
            4'hb: sym_grid = 4'h7;
            4'h7: sym_grid = 4'h8;
            4'h8: sym_grid = 4'h9;
            4'h9: sym_grid = 4'ha;
            4'hc: sym_grid = 4'hb;
            4'he: sym_grid = 4'hc;
            4'h0: sym_grid = 4'hd;
            4'hf: sym_grid = 4'he;
            default: sym_grid = 4'hf;
        endcase
    endfunction

    function automatic logic [15:0] row_nom(input logic [1:0] r);
        case (r)
            2'h0: row_nom = 16'd697;
            2'h1: row_nom = 16'd770;
            2'h2: row_nom = 16'd852;
            default: row_nom = 16'd941;
        endcase
    endfunction

    function automatic logic [15:0] col_nom(input logic [1:0] c);
        case (c)
            2'h0: col_nom = 16'd1209;
            2'h1: col_nom = 16'd1336;
            2'h2: col_nom = 16'd1477;
            default: col_nom = 16'd1633;
        endcase
    endfunction

    // Frequency in 0.1 Hz; percent error in 0.01 %, clamped to the legal span
    function automatic logic [15:0] tone_inc(input logic [15:0] nom, input logic signed [15:0] pct,
                                             input logic signed [15:0] hz);
        logic signed [15:0] p;
        logic signed [39:0] f;
        p = pct > 16'sd2000 ? 16'sd2000 : (pct < -16'sd2000 ? -16'sd2000 : pct); // [R05]
        f = 40'(nom) * 40'sd10 * (40'sd10000 + 40'(p)) / 40'sd10000 + 40'(hz); // [R06]
        if (f < 0) begin
            f = '0;
        end
        // Phase step per 8 kHz sample for a 16-bit accumulator
        tone_inc = 16'((f * 40'sd53687) >>> 16);
    endfunction

    function automatic logic signed [11:0] sine(input logic [15:0] ph);
        logic [3:0] i;
        logic [10:0] m;
        i = ph[14] ? ~ph[13:10] : ph[13:10];
        case (i)
            4'h0: m = 11'd100;
            4'h1: m = 11'd300;
            4'h2: m = 11'd497;
            4'h3: m = 11'd690;
            4'h4: m = 11'd875;
            4'h5: m = 11'd1052;
            4'h6: m = 11'd1219;
            4'h7: m = 11'd1375;
            4'h8: m = 11'd1517;
            4'h9: m = 11'd1645;
            4'ha: m = 11'd1757;
            4'hb: m = 11'd1851;
            4'hc: m = 11'd1927;
            4'hd: m = 11'd1986;
            4'he: m = 11'd2025;
            default: m = 11'd2045;
        endcase
        sine = ph[15] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    endfunction

    // Level in 0.1 dB becomes a right shift, 6 dB per step; coarse but cheap
    function automatic logic [3:0] lvl_shift(input logic signed [15:0] db);
        logic signed [15:0] s;
        s = -db / 16'sd60;
        lvl_shift = s < 0 ? 4'h0 : (s > 16'sd15 ? 4'hf : s[3:0]);
    endfunction

    wire [3:0] grid = sym_grid(sym);
    wire [15:0] inc_r = tone_inc(row_nom(grid[3:2]), ferr_pct.row, ferr_hz.row + so.row_hz); // [R16] [R09]
    wire [15:0] inc_c = tone_inc(col_nom(grid[1:0]), ferr_pct.col, ferr_hz.col + so.col_hz); // [R16] [R09]
    wire [3:0] sh_r = lvl_shift(row_db + so.row_lvl);
    wire [3:0] sh_c = lvl_shift(col_db + so.col_lvl);
    wire signed [15:0] sin_r = 16'(sine(ph_r)) <<< 3;
    wire signed [15:0] sin_c = 16'(sine(ph_c)) <<< 3;
    wire signed [15:0] mix = (sin_r >>> sh_r) + (sin_c >>> sh_c); // [R17]
    wire tone_on = (state == DTG_TONE || state == DTG_KEY) && tx_ok;

    // Timing targets; a negative pause offset may shorten the gap to nothing
    wire signed [16:0] on_t = 17'(on_ms) + 17'(so.dur_ms);
    wire signed [16:0] pa_t = 17'(pause_ms) + 17'(so.pause_ms); // [R12]
    wire tone_done = tmr >= (on_t < 17'sd1 ? 16'h1 : on_t[15:0]); // [R07]
    wire pause_done = tmr >= (pa_t < 0 ? 16'h0 : pa_t[15:0]); // [R07] [R12]
    wire key_held = ctrl[`DTG_C_TOGGLE] ? tog_on : keypad[`DTG_K_DOWN]; // [R01] [R02]
    wire start_ok = n_len != 4'h0 && n_len <= 4'h8;
    wire need_hook = !hook_now && ctrl_now[`DTG_C_DLY_EN];

    always_comb begin
        next_state = state;
        case (state)
            DTG_IDLE: begin
                if (start_req && start_ok && need_hook) begin
                    next_state = DTG_HOOKWAIT; // [R13]
                end else if (start_req && start_ok && tx_ok) begin
                    next_state = DTG_TONE; // [R08] [R14]
                end else if (key_held) begin
                    next_state = DTG_KEY;
                end
            end
            DTG_KEY: begin
                if (!key_held) begin
                    next_state = DTG_IDLE; // [R01] [R02]
                end
            end
            DTG_HOOKWAIT: begin
                if (tmr >= delay_ms) begin
                    next_state = DTG_TONE; // [R13]
                end
            end
            DTG_TONE: begin
                if (tone_done) begin
                    next_state = DTG_PAUSE;
                end
            end
            DTG_PAUSE: begin
                if (pause_done) begin
                    next_state = last_digit ? DTG_IDLE : DTG_TONE; // [R08]
                end
            end
            default: next_state = DTG_IDLE;
        endcase
        if (stop_req) begin
            next_state = DTG_IDLE; // [R17]
        end
    end

    // Register writes
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= '0;
            lvl_tt <= '0;
            lvl_rc <= '0;
            ferr_pct <= '0;
            ferr_hz <= '0;
            on_ms <= `DTG_RST_ON_MS;
            pause_ms <= `DTG_RST_PAUSE_MS;
            delay_ms <= `DTG_RST_DELAY_MS;
            digits <= '0;
            keypad <= '0;
            ofs_sel <= '0;
            for (int i = 0; i < 16; i++) begin
                ofs_mem[i] <= '0; // [R11]
            end
        end else if (ce_i && bus_i.wr) begin
            case (bus_i.addr)
                `DTG_CTRL: ctrl <= {bus_i.wdata[11:6], 2'b00, bus_i.wdata[3:0]};
                `DTG_LVL_TT: lvl_tt <= bus_i.wdata;
                `DTG_LVL_RC: lvl_rc <= bus_i.wdata;
                `DTG_FERR_PCT: ferr_pct <= bus_i.wdata;
                `DTG_FERR_HZ: ferr_hz <= bus_i.wdata;
                `DTG_TIMING: {pause_ms, on_ms} <= bus_i.wdata;
                `DTG_DELAY: delay_ms <= bus_i.wdata[15:0];
                `DTG_DIGITS: digits <= bus_i.wdata;
                `DTG_KEYPAD: keypad <= bus_i.wdata[4:0];
                `DTG_OFS_SEL: ofs_sel <= bus_i.wdata[3:0];
                `DTG_OFS_LVL: {ofs_mem[ofs_sel].col_lvl, ofs_mem[ofs_sel].row_lvl} <= bus_i.wdata; // [R09]
                `DTG_OFS_FRQ: {ofs_mem[ofs_sel].col_hz, ofs_mem[ofs_sel].row_hz} <= bus_i.wdata; // [R09]
                `DTG_OFS_TIM: {ofs_mem[ofs_sel].pause_ms, ofs_mem[ofs_sel].dur_ms} <= bus_i.wdata; // [R09]
                default: ;
            endcase
        end
    end

    // Read data, valid only in the cycle after the strobe
    logic [31:0] rd_mux;
    wire [31:0] stat = {16'h0, 3'h0, refused, dig_idx, tx_ok, tog_on, off_hook, 1'b0, state, 2'b00};
    always_comb begin
        case (bus_i.addr)
            `DTG_CTRL: rd_mux = {20'h0, ctrl};
            `DTG_LVL_TT: rd_mux = {twist_db, tot_db};
            `DTG_LVL_RC: rd_mux = {col_db, row_db};
            `DTG_FERR_PCT: rd_mux = ferr_pct;
            `DTG_FERR_HZ: rd_mux = ferr_hz;
            `DTG_TIMING: rd_mux = {pause_ms, on_ms};
            `DTG_DELAY: rd_mux = {16'h0, delay_ms};
            `DTG_DIGITS: rd_mux = digits;
            `DTG_KEYPAD: rd_mux = {27'h0, keypad};
            `DTG_OFS_SEL: rd_mux = {28'h0, ofs_sel};
            `DTG_OFS_LVL: rd_mux = {ofs_mem[ofs_sel].col_lvl, ofs_mem[ofs_sel].row_lvl};
            `DTG_OFS_FRQ: rd_mux = {ofs_mem[ofs_sel].col_hz, ofs_mem[ofs_sel].row_hz};
            `DTG_OFS_TIM: rd_mux = {ofs_mem[ofs_sel].pause_ms, ofs_mem[ofs_sel].dur_ms};
            `DTG_STATUS: rd_mux = stat;
            default: rd_mux = '0;
        endcase
    end

    // Sequencer, timers and line outputs
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= DTG_IDLE;
            off_hook <= 1'b0;
            tog_on <= 1'b0;
            refused <= 1'b0;
            dig_idx <= '0;
            ms_pre <= '0;
            smp_pre <= '0;
            tmr <= '0;
            ph_r <= '0;
            ph_c <= '0;
            rdata_o <= '0;
            off_hook_o <= 1'b0;
            line_tx_en_o <= 1'b0;
            sample_o <= '0;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            rdata_o <= bus_i.rd ? rd_mux : '0;
            ms_pre <= ms_tick ? '0 : ms_pre + 16'h1;
            smp_pre <= smp_tick ? '0 : smp_pre + 12'h1;
            if (next_state != state) begin
                tmr <= '0;
            end else if (ms_tick) begin
                tmr <= tmr + 16'h1;
            end
            if (wr_ctrl) begin
                off_hook <= bus_i.wdata[`DTG_C_HOOK];
            end
            if (state == DTG_IDLE && next_state == DTG_HOOKWAIT) begin
                off_hook <= 1'b1; // [R13]
            end
            if (stop_req || (wr_key && !ctrl[`DTG_C_TOGGLE])) begin
                tog_on <= 1'b0;
            end else if (key_rise && ctrl[`DTG_C_TOGGLE]) begin
                tog_on <= !tog_on; // [R02]
            end
            if (start_req) begin
                refused <= !start_ok || (!need_hook && !tx_ok); // [R14]
            end
            if (state == DTG_IDLE) begin
                dig_idx <= '0;
            end else if (state == DTG_PAUSE && next_state == DTG_TONE) begin
                dig_idx <= dig_idx + 3'h1; // [R08]
            end
            // Phases restart per digit so every burst begins at zero crossing
            if (!tone_on) begin
                ph_r <= '0;
                ph_c <= '0;
            end else if (smp_tick) begin
                ph_r <= ph_r + inc_r;
                ph_c <= ph_c + inc_c;
            end
            sample_o <= !tone_on ? '0 : (smp_tick ? mix : sample_o); // [R17] [R15]
            off_hook_o <= off_hook;
            line_tx_en_o <= tone_on; // [R15]
            busy_o <= state != DTG_IDLE;
        end
    end
endmodule

// file: inc/dtg_consts.svh
`ifndef DTG_CONSTS_SVH
`define DTG_CONSTS_SVH
// Register offsets (byte addresses)
`define DTG_CTRL 8'h00
`define DTG_LVL_TT 8'h04
`define DTG_LVL_RC 8'h08
`define DTG_FERR_PCT 8'h0c
`define DTG_FERR_HZ 8'h10
`define DTG_TIMING 8'h14
`define DTG_DELAY 8'h18
`define DTG_DIGITS 8'h1c
`define DTG_KEYPAD 8'h20
`define DTG_OFS_SEL 8'h24
`define DTG_OFS_LVL 8'h28
`define DTG_OFS_FRQ 8'h2c
`define DTG_OFS_TIM 8'h30
`define DTG_STATUS 8'h34
// Control field positions
`define DTG_C_TOGGLE 0
`define DTG_C_DLY_EN 1
`define DTG_C_LVL_RC 2
`define DTG_C_HOOK 3
`define DTG_C_START 4
`define DTG_C_STOP 5
`define DTG_C_ACM 7:6
`define DTG_C_LEN 11:8
`define DTG_K_DOWN 4
// Reset values
`define DTG_RST_ON_MS 16'h0046
`define DTG_RST_PAUSE_MS 16'h0046
`define DTG_RST_DELAY_MS 16'h03e8
// Timing
`define DTG_CLK_HZ 25000000
`define DTG_MS_CYCLES (`DTG_CLK_HZ / 1000)
`define DTG_SAMPLE_HZ 8000
`define DTG_SAMPLE_CYCLES (`DTG_CLK_HZ / `DTG_SAMPLE_HZ)
`define DTG_PCT_LIMIT 2000
`endif

// file: inc/dtg_pkg.sv
package dtg_pkg;
    typedef enum logic [2:0] {
        DTG_IDLE = 3'b000,
        DTG_HOOKWAIT = 3'b001,
        DTG_TONE = 3'b011,
        DTG_PAUSE = 3'b010,
        DTG_KEY = 3'b110
    } dtg_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dtg_bus_s;

    typedef struct packed {
        logic signed [15:0] col_lvl;
        logic signed [15:0] row_lvl;
        logic signed [15:0] col_hz;
        logic signed [15:0] row_hz;
        logic signed [15:0] pause_ms;
        logic signed [15:0] dur_ms;
    } dtg_ofs_s;

    typedef struct packed {
        logic signed [15:0] col;
        logic signed [15:0] row;
    } dtg_pair_s;

    typedef enum logic [1:0] {
        DTG_AC_HIGHZ = 2'h0,
        DTG_AC_RINGER = 2'h1,
        DTG_AC_TERM = 2'h2
    } dtg_acm_e;
endpackage

// file: verif/dtg_dial_gen_bench.sv
`timescale 1ns/10ps
`include "dtg_consts.svh"
module dtg_dial_gen_bench;
    import dtg_pkg::*;
    localparam int MS = 20;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    dtg_bus_s bus_i = '0;
    logic [31:0] rdata_o;
    logic off_hook_o;
    logic line_tx_en_o;
    logic busy_o;
    logic signed [15:0] sample_o;
    int on_len;
    int bursts;
    logic heard;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] rv;
    int n;

    always #20 core_clk_i = ~core_clk_i;

    dtg_dial_gen #(.MS_CYCLES(MS)) i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .off_hook_o(off_hook_o), .line_tx_en_o(line_tx_en_o),
        .sample_o(sample_o), .busy_o(busy_o));
    dtg_line_model i_line (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .off_hook_i(off_hook_o),
        .tx_en_i(line_tx_en_o), .sample_i(sample_o), .on_len_o(on_len), .bursts_o(bursts), .heard_o(heard));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Durations are counted on a free ms tick, so one ms of slack
    task automatic near(input string name, input int exp, input int got);
        compares++;
        if (got < exp - MS || got > exp + MS) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus_i <= '0;
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        bus_i <= '0;
        @(negedge core_clk_i);
        rv = rdata_o;
        check(name, exp, rv);
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? line_tx_en_o : (sel == 1) ? busy_o : off_hook_o;
    endfunction

    // sel 0 tone, 1 busy, 2 hook
    task automatic wait_for(input int sel, input logic val, input int max, output int cyc);
        cyc = 0;
        while (pick(sel) !== val) begin
            @(negedge core_clk_i);
            cyc++;
            if (cyc > max) begin
                mismatches++;
                $display("ERROR wait %0d expected %b seen timeout", sel, val);
                end_sim();
            end
        end
    endtask

    initial begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd("timing", `DTG_TIMING, {`DTG_RST_PAUSE_MS, `DTG_RST_ON_MS});
        rd("delay", `DTG_DELAY, {16'h0000, `DTG_RST_DELAY_MS});
        for (int s = 0; s < 16; s++) begin
            wr(`DTG_OFS_SEL, 32'(s));
            rd("ofs lvl", `DTG_OFS_LVL, 32'h0000_0000);
            rd("ofs frq", `DTG_OFS_FRQ, 32'h0000_0000);
            rd("ofs tim", `DTG_OFS_TIM, 32'h0000_0000);
        end
        rd("unmapped", 8'h3c, 32'h0000_0000);
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        wr(`DTG_DELAY, 32'h0000_0005);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        rd("frozen", `DTG_DELAY, {16'h0000, `DTG_RST_DELAY_MS});
        wr(`DTG_DELAY, 32'h0000_0005);
        wr(`DTG_LVL_TT, 32'h0014_ff9c);
        rd("rc form", `DTG_LVL_RC, 32'hffa6_ff92);
        wr(`DTG_CTRL, 32'h0000_0004);
        wr(`DTG_LVL_RC, 32'hffb0_ff88);
        rd("tt form", `DTG_LVL_TT, 32'h0028_ff9c);
        wr(`DTG_CTRL, 32'h0000_0000);
        wr(`DTG_LVL_TT, 32'h0000_0000);
        wr(`DTG_TIMING, 32'h0002_0003);
        wr(`DTG_DIGITS, 32'h0000_0021);
        for (int m = 0; m < 2; m++) begin
            wr(`DTG_CTRL, 32'h0000_0110 | 32'(m << 6));
            rd("status", `DTG_STATUS, 32'h0000_1000);
            check("refused", 32'h1, 32'(rv[12]));
            check("busy", 32'h0, 32'(busy_o));
        end
        wr(`DTG_CTRL, 32'h0000_0190);
        wait_for(0, 1'b1, 10, n);
        check("on hook", 32'h0, 32'(off_hook_o));
        wait_for(1, 1'b0, 800, n);
        wr(`DTG_CTRL, 32'h0000_0112);
        wait_for(0, 1'b1, 400, n);
        near("hook delay", 5 * MS, n);
        check("off hook", 32'h1, 32'(off_hook_o));
        wait_for(1, 1'b0, 800, n);
        wr(`DTG_OFS_SEL, 32'h0000_0001);
        wr(`DTG_OFS_TIM, 32'h0004_0003);
        wr(`DTG_CTRL, 32'h0000_0218);
        wait_for(0, 1'b1, 10, n);
        wait_for(0, 1'b0, 400, n);
        near("first on", 6 * MS, n);
        wait_for(0, 1'b1, 400, n);
        near("first pause", 6 * MS, n);
        wait_for(1, 1'b0, 800, n);
        near("second on", 3 * MS, on_len);
        check("bursts", 32'd4, 32'(bursts));
        wr(`DTG_TIMING, 32'h0002_0064);
        wr(`DTG_CTRL, 32'h0000_0118);
        wait_for(0, 1'b1, 10, n);
        repeat (30) @(posedge core_clk_i);
        wr(`DTG_CTRL, 32'h0000_0028);
        wait_for(0, 1'b0, 3, n);
        for (int s = 0; s < 16; s++) begin
            wr(`DTG_KEYPAD, 32'h0000_0010 | 32'(s));
            wait_for(0, 1'b1, 10, n);
            repeat (12) @(posedge core_clk_i);
            wr(`DTG_KEYPAD, 32'(s));
            wait_for(0, 1'b0, 5, n);
        end
        wr(`DTG_KEYPAD, 32'h0000_0015);
        repeat (7000) @(posedge core_clk_i);
        check("held tone", 32'h1, 32'(line_tx_en_o));
        check("heard", 32'h1, 32'(heard));
        wr(`DTG_KEYPAD, 32'h0000_0005);
        wait_for(0, 1'b0, 5, n);
        wr(`DTG_CTRL, 32'h0000_0009);
        wr(`DTG_KEYPAD, 32'h0000_0013);
        wait_for(0, 1'b1, 10, n);
        wr(`DTG_KEYPAD, 32'h0000_0003);
        repeat (20) @(posedge core_clk_i);
        check("toggle hold", 32'h1, 32'(line_tx_en_o));
        wr(`DTG_KEYPAD, 32'h0000_0013);
        wait_for(0, 1'b0, 5, n);
        end_sim();
    end
endmodule

// file: verif/dtg_dial_gen_properties.sv
`timescale 1ns/10ps
`include "dtg_consts.svh"
module dtg_dial_gen_properties #(
    parameter int MS_CYCLES = 25000
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Register port
    input wire dtg_pkg::dtg_bus_s bus_i,
    input wire logic [31:0] rdata_o,
    // Line side
    input wire logic off_hook_o,
    input wire logic line_tx_en_o,
    input wire logic signed [15:0] sample_o,
    input wire logic busy_o
);
    import dtg_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire ctrl_wr = ce_i && bus_i.wr && (bus_i.addr == `DTG_CTRL);
    wire stop_wr = ctrl_wr && bus_i.wdata[`DTG_C_STOP] && !bus_i.wdata[`DTG_C_START];
    // Off-hook start without the delay option must reach the tone quickly
    wire go_wr = ctrl_wr && bus_i.wdata[`DTG_C_START] && bus_i.wdata[`DTG_C_HOOK] && !bus_i.wdata[`DTG_C_DLY_EN]
        && !bus_i.wdata[`DTG_C_STOP] && (bus_i.wdata[`DTG_C_LEN] inside {[4'h1:4'h8]}) && !busy_o;

    chk_start_tone: assert property (go_wr |-> ##[1:3] line_tx_en_o)
        else $error("start off hook did not reach tone");
    chk_tx_busy: assert property ($rose(line_tx_en_o) |-> busy_o)
        else $error("tone sent while generator idle");
    chk_stop_idle: assert property (stop_wr |-> ##2 !busy_o)
        else $error("stop did not return to idle");
    chk_idle_quiet: assert property (!busy_o && ($past(busy_o) == 1'b0) |-> !line_tx_en_o)
        else $error("line driven while idle");
    chk_muted_zero: assert property (!line_tx_en_o && !$past(line_tx_en_o) |-> sample_o == 16'h0000)
        else $error("sample not muted");
    chk_tone_min: assert property ($rose(line_tx_en_o) |-> line_tx_en_o [*8])
        else $error("tone shorter than minimum");
    chk_delay_wait: assert property ($rose(off_hook_o) && $rose(busy_o) |-> !line_tx_en_o [*8])
        else $error("tone before off-hook delay");
    // Samples move only on the 8 kHz tick, or drop to zero on mute
    chk_sample_tick: assert property ($changed(sample_o) && line_tx_en_o |=>
        ($stable(sample_o) || !line_tx_en_o || sample_o == 16'h0000) [*8])
        else $error("sample changed between ticks");
endmodule

bind dtg_dial_gen dtg_dial_gen_properties #(.MS_CYCLES(MS_CYCLES)) i_props (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .bus_i(bus_i), .rdata_o(rdata_o), .off_hook_o(off_hook_o),
    .line_tx_en_o(line_tx_en_o), .sample_o(sample_o), .busy_o(busy_o));

// file: verif/dtg_line_model.sv
`timescale 1ns/10ps
// Passive line: it only listens, so it never stalls the generator
module dtg_line_model (
    // Clock, reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Line side
    input wire logic off_hook_i,
    input wire logic tx_en_i,
    input wire logic signed [15:0] sample_i,
    // Observations
    output int on_len_o,
    output int bursts_o,
    output logic heard_o
);
    int run;
    logic tx_q;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run <= 0;
            tx_q <= 1'b0;
            on_len_o <= 0;
            bursts_o <= 0;
            heard_o <= 1'b0;
        end else begin
            tx_q <= tx_en_i;
            run <= (tx_en_i != tx_q) ? 1 : run + 1;
            if (tx_q && !tx_en_i) begin
                on_len_o <= run;
            end
            if (tx_en_i && !tx_q) begin
                bursts_o <= bursts_o + 1;
            end
            heard_o <= heard_o | (tx_en_i && sample_i != 16'h0000);
        end
    end
endmodule
